// file: clock_gating_params.svh
// constants for the peripheral clock gating block
// assumes inclusion by bare name from the design file
`ifndef CLOCK_GATING_PARAMS_SVH
`define CLOCK_GATING_PARAMS_SVH

`define OFF_GATE_A        32'h0000_0000
`define OFF_GATE_B        32'h0000_0004
`define OFF_SLEEP_CTRL    32'h0000_0008
`define OFF_ANALOG_CTRL   32'h0000_000c
`define OFF_STATUS        32'h0000_0010
`define ADDR_LSB          2
`define ADDR_BITS         5

`define GATE_A_MASK       8'h2c
`define GATE_B_MASK       8'h81
`define GATE_RESET        8'h00
`define CTRL_RESET        8'h00
`define BIT_TIMER8        5
`define BIT_TIMER16       3
`define BIT_SPI           2
`define BIT_USB           7
`define BIT_SERIAL        0

`define SLEEP_MODE_LSB    1
`define SLEEP_MODE_MSB    3
`define SLEEP_CTRL_MASK   8'h0e
`define ANALOG_CTRL_MASK  8'h07
`define BIT_CMP_OFF       0
`define BIT_CMP_USE_REF   1
`define BIT_WDT_EN        2

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// file: clock_gating_pkg.sv
// types for the peripheral clock gating block
// assumes nothing of its surroundings
package clock_gating_pkg;
   typedef enum logic [2:0] {
      sleep_idle       = 3'b000,
      sleep_powerdown  = 3'b010,
      sleep_powersave  = 3'b011,
      sleep_standby    = 3'b110,
      sleep_ext_stby   = 3'b111
   } sleep_mode_e;
   typedef enum logic [1:0] {
      bus_idle  = 2'b00,
      bus_resp  = 2'b01
   } bus_state_e;
endpackage

// file: peripheral_clock_gating.sv
// peripheral clock gating and sleep power control, one AXI4-Lite slave
// assumes the gated clocks are derived from aclk and that fuse and sleep inputs are static or synchronous
// What this block does
// - a set gate bit stops that clock, freezes state and blocks register access
// - gating never releases resources the peripheral holds
// - clearing a gate bit resumes the clock with unchanged state
// - gating acts in active and idle states regardless of sleep mode
// - gate_a bit 5 stops the 8-bit timer clock
// - gate_a bit 3 stops the 16-bit timer clock
// - gate_a bit 2 stops the spi clock
// - gate_b bit 7 stops the usb clock
// - gate_b bit 0 stops the serial port clock
// - reserved gate bits always read zero
// - comparator is forced off in every sleep mode except idle
// - reference stays on in sleep when comparator uses it and is enabled
// - reference is on only while brown-out detector or comparator is on, or comparator is set to use it
// - brown-out detector enabled by fuses keeps running in all sleep modes
// - enabled watchdog keeps running in all sleep modes
// - input buffers are off in sleep modes that stop the io clock
// - wake-up pin buffers stay on even when io clock stops
// - digital input disable register turns off selected analog pin buffers always
// - debug fuse keeps main clock source running in every sleep mode
// - power-down, power-save and standby stop the cpu and io clocks, not the gated peripheral clocks; idle only the cpu clock
`timescale 1ns/1ps
`include "clock_gating_params.svh"

module peripheral_clock_gating
   import clock_gating_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        sleep_active,
   input  wire logic        brownout_enabled_fuse,
   input  wire logic        debug_enable_fuse,
   input  wire logic [7:0]  wake_pin_mask,
   input  wire logic [7:0]  digital_input_disable_reg,
   output      logic        clk_timer8,
   output      logic        clk_timer16,
   output      logic        clk_spi,
   output      logic        clk_usb,
   output      logic        clk_serial,
   output      logic [4:0]  periph_access_en,
   output      logic        clk_cpu_en,
   output      logic        clk_io_en,
   output      logic        main_osc_en,
   output      logic        comparator_en,
   output      logic        vref_en,
   output      logic        brownout_en,
   output      logic        watchdog_run,
   output      logic [7:0]  input_buffer_en
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0]  gate_a_reg;
   logic [7:0]  gate_b_reg;
   logic [7:0]  sleep_ctrl_reg;
   logic [7:0]  analog_ctrl_reg;

   logic [2:0]  sleep_sync_reg;
   logic        sleep_seen_reg;
   logic [4:0]  gate_hold_reg;

   bus_state_e  wr_state_reg;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [31:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   // ----------------------------------------
   // sleep state decode
   // ----------------------------------------
   sleep_mode_e sleep_mode;
   wire         in_sleep;
   wire         deep_sleep;
   wire         known_mode;

   assign sleep_mode = sleep_mode_e'(sleep_ctrl_reg[`SLEEP_MODE_MSB:`SLEEP_MODE_LSB]);
   assign in_sleep   = sleep_seen_reg;
   assign known_mode = (sleep_mode == sleep_idle) || (sleep_mode == sleep_powerdown) ||
                       (sleep_mode == sleep_powersave) || (sleep_mode == sleep_standby) ||
                       (sleep_mode == sleep_ext_stby);
   // reserved codes are treated as idle
   assign deep_sleep = in_sleep && known_mode && (sleep_mode != sleep_idle);

   // every sleep mode stops the cpu clock; only the deep modes also stop the io clock
   assign clk_cpu_en  = !in_sleep;
   assign clk_io_en   = !deep_sleep;
   // the standby modes and the debug fuse keep the main oscillator up
   assign main_osc_en = !deep_sleep || debug_enable_fuse ||
                        (sleep_mode == sleep_standby) || (sleep_mode == sleep_ext_stby);

   // ----------------------------------------
   // analog and always-on domains
   // ----------------------------------------
   wire cmp_sw_on;
   wire cmp_uses_ref;

   assign cmp_sw_on     = !analog_ctrl_reg[`BIT_CMP_OFF];
   assign cmp_uses_ref  = cmp_sw_on && analog_ctrl_reg[`BIT_CMP_USE_REF];
   // the comparator drops out in deep sleep on its own, without software
   assign comparator_en = cmp_sw_on && !deep_sleep;
   // the brown-out detector follows its fuses alone, asleep or awake
   assign brownout_en   = brownout_enabled_fuse;
   // a comparator still routed to the reference keeps it alive through deep sleep
   assign vref_en       = brownout_enabled_fuse || comparator_en || cmp_uses_ref;
   // the watchdog enable is not touched by any sleep mode
   assign watchdog_run  = analog_ctrl_reg[`BIT_WDT_EN];

   // is left to software: vref_en gives the moment the reference restarts
   assign input_buffer_en = (deep_sleep ? wake_pin_mask : 8'hff)
                            & ~digital_input_disable_reg;

   // ----------------------------------------
   // clock gates
   // ----------------------------------------
   wire [4:0] gate_req;
   wire [4:0] gated_clk;

   assign gate_req = {gate_b_reg[`BIT_SERIAL], gate_b_reg[`BIT_USB], gate_a_reg[`BIT_SPI],
                      gate_a_reg[`BIT_TIMER16], gate_a_reg[`BIT_TIMER8]};

   // gate enable is latched on the falling edge, so it only changes while aclk is low
   always_ff @(negedge aclk) begin
      if (!aresetn) begin
         gate_hold_reg <= 5'h00;
      end else begin
         gate_hold_reg <= gate_req;
      end
   end

   // one gate per peripheral, in the bit order of gate_req
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : gate_gen
         // peripheral keeps its flops while stopped; no reset is sent on gating
         assign gated_clk[g]        = aclk & ~gate_hold_reg[g];
         // access is cut in the cycle after the write, before the clock stops at the falling edge
         assign periph_access_en[g] = ~gate_req[g];
      end
   endgenerate

   // gated clocks stay low while their gate is closed
   assign clk_timer8  = gated_clk[0];
   assign clk_timer16 = gated_clk[1];
   assign clk_spi     = gated_clk[2];
   assign clk_usb     = gated_clk[3];
   assign clk_serial  = gated_clk[4];

   // ----------------------------------------
   // sleep input synchroniser
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_sync_reg <= 3'b000;
         sleep_seen_reg <= 1'b0;
      end else begin
         sleep_sync_reg <= {sleep_sync_reg[1:0], sleep_active};
         // a level counts only once the last two stages agree, so a short glitch is not seen
         if (sleep_sync_reg[2] == sleep_sync_reg[1]) begin
            sleep_seen_reg <= sleep_sync_reg[2];
         end
      end
   end

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   wire        aw_take;
   wire        w_take;
   wire        have_aw;
   wire        have_w;
   wire [31:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  wr_strb;
   wire        do_write;
   wire        wr_hit;
   wire        wr_lane0;
   wire [31:0] wr_offset;
   wire        wr_sel_gate_a;
   wire        wr_sel_gate_b;
   wire        wr_sel_sleep;
   wire        wr_sel_analog;
   wire        wr_sel_status;

   assign s_axi_awready = (wr_state_reg == bus_idle) && !aw_held_reg;
   assign s_axi_wready  = (wr_state_reg == bus_idle) && !w_held_reg;
   assign aw_take  = s_axi_awvalid && s_axi_awready;
   assign w_take   = s_axi_wvalid && s_axi_wready;
   assign have_aw  = aw_held_reg || aw_take;
   assign have_w   = w_held_reg || w_take;
   assign wr_addr  = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   assign wr_data  = w_held_reg ? wdata_reg : s_axi_wdata;
   assign wr_strb  = w_held_reg ? wstrb_reg : s_axi_wstrb;
   assign do_write = (wr_state_reg == bus_idle) && have_aw && have_w;
   assign wr_lane0 = wr_strb[0];

   // ----------------------------------------
   // write address decode
   // ----------------------------------------
   // only the low address bits decode, so every register also answers at aliases higher up
   assign wr_offset     = {{(32-`ADDR_BITS){1'b0}}, wr_addr[`ADDR_BITS-1:0]};
   assign wr_sel_gate_a = (wr_offset == `OFF_GATE_A);
   assign wr_sel_gate_b = (wr_offset == `OFF_GATE_B);
   assign wr_sel_sleep  = (wr_offset == `OFF_SLEEP_CTRL);
   assign wr_sel_analog = (wr_offset == `OFF_ANALOG_CTRL);
   assign wr_sel_status = (wr_offset == `OFF_STATUS);
   // an unmapped address is answered with an error and changes nothing
   assign wr_hit        = wr_sel_gate_a || wr_sel_gate_b || wr_sel_sleep || wr_sel_analog || wr_sel_status;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= bus_idle;
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         awaddr_reg   <= 32'h0000_0000;
         wdata_reg    <= 32'h0000_0000;
         wstrb_reg    <= 4'h0;
         bresp_reg    <= `RESP_OKAY;
      end else begin
         case (wr_state_reg)
            // address and data may come in either order; whichever comes first is parked
            bus_idle: begin
               if (do_write) begin
                  aw_held_reg  <= 1'b0;
                  w_held_reg   <= 1'b0;
                  bresp_reg    <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                  wr_state_reg <= bus_resp;
               end else begin
                  if (aw_take) begin
                     aw_held_reg <= 1'b1;
                     awaddr_reg  <= s_axi_awaddr;
                  end
                  if (w_take) begin
                     w_held_reg <= 1'b1;
                     wdata_reg  <= s_axi_wdata;
                     wstrb_reg  <= s_axi_wstrb;
                  end
               end
            end
            bus_resp: begin
               if (s_axi_bready) begin
                  wr_state_reg <= bus_idle;
               end
            end
            default: begin
               wr_state_reg <= bus_idle;
            end
         endcase
      end
   end

   // the write answer stands until the master takes it
   assign s_axi_bvalid = (wr_state_reg == bus_resp);
   assign s_axi_bresp  = bresp_reg;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   wire       wr_en;
   wire [7:0] gate_a_next;
   wire [7:0] gate_b_next;
   wire [7:0] sleep_ctrl_next;
   wire [7:0] analog_ctrl_next;

   // a write with the low byte lane switched off is answered but changes nothing
   assign wr_en            = do_write && wr_lane0;
   // reserved gate bits are masked on the way in, so they can never read back as one
   assign gate_a_next      = (wr_en && wr_sel_gate_a) ? (wr_data[7:0] & `GATE_A_MASK) : gate_a_reg;
   assign gate_b_next      = (wr_en && wr_sel_gate_b) ? (wr_data[7:0] & `GATE_B_MASK) : gate_b_reg;
   assign sleep_ctrl_next  = (wr_en && wr_sel_sleep) ? (wr_data[7:0] & `SLEEP_CTRL_MASK) : sleep_ctrl_reg;
   assign analog_ctrl_next = (wr_en && wr_sel_analog) ? (wr_data[7:0] & `ANALOG_CTRL_MASK) : analog_ctrl_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gate_a_reg      <= `GATE_RESET;
         gate_b_reg      <= `GATE_RESET;
         sleep_ctrl_reg  <= `CTRL_RESET;
         analog_ctrl_reg <= `CTRL_RESET;
      end else begin
         gate_a_reg      <= gate_a_next;
         gate_b_reg      <= gate_b_next;
         sleep_ctrl_reg  <= sleep_ctrl_next;
         analog_ctrl_reg <= analog_ctrl_next;
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   wire        ar_take;
   wire [7:0]  status_word;
   wire [31:0] rd_offset;
   wire        rd_sel_gate_a;
   wire        rd_sel_gate_b;
   wire        rd_sel_sleep;
   wire        rd_sel_analog;
   wire        rd_sel_status;
   wire [7:0]  rd_byte;
   wire [31:0] rd_word;
   wire        rd_hit;

   // a new read address is refused while the previous answer still waits
   assign s_axi_arready = !rvalid_reg;
   assign ar_take       = s_axi_arvalid && s_axi_arready;
   // status, msb first: reference, comparator, oscillator, io clock, cpu clock, sleep, brown-out, watchdog
   assign status_word   = {vref_en, comparator_en, main_osc_en, clk_io_en, clk_cpu_en, in_sleep,
                           brownout_en, watchdog_run};

   // ----------------------------------------
   // read data select
   // ----------------------------------------
   assign rd_offset     = {{(32-`ADDR_BITS){1'b0}}, s_axi_araddr[`ADDR_BITS-1:0]};
   assign rd_sel_gate_a = (rd_offset == `OFF_GATE_A);
   assign rd_sel_gate_b = (rd_offset == `OFF_GATE_B);
   assign rd_sel_sleep  = (rd_offset == `OFF_SLEEP_CTRL);
   assign rd_sel_analog = (rd_offset == `OFF_ANALOG_CTRL);
   assign rd_sel_status = (rd_offset == `OFF_STATUS);
   assign rd_hit        = rd_sel_gate_a || rd_sel_gate_b || rd_sel_sleep || rd_sel_analog || rd_sel_status;
   assign rd_byte       = ({8{rd_sel_gate_a}} & gate_a_reg) |
                          ({8{rd_sel_gate_b}} & gate_b_reg) |
                          ({8{rd_sel_sleep}}  & sleep_ctrl_reg) |
                          ({8{rd_sel_analog}} & analog_ctrl_reg) |
                          ({8{rd_sel_status}} & status_word);
   // registers sit in the low byte; the upper bytes read as zero
   assign rd_word       = {24'h000000, rd_byte};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // read data and response come from flops and stand until taken
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

endmodule

// file: peripheral_clock_gating_properties.sv
// concurrent checks on the ports of the peripheral clock gating block
// assumes it is bound to every peripheral_clock_gating instance
`timescale 1ns/1ps

module peripheral_clock_gating_checker (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       sleep_active,
   input wire logic       brownout_enabled_fuse,
   input wire logic       debug_enable_fuse,
   input wire logic [7:0] wake_pin_mask,
   input wire logic [7:0] digital_input_disable_reg,
   input wire logic       clk_timer8,
   input wire logic       clk_timer16,
   input wire logic       clk_spi,
   input wire logic       clk_usb,
   input wire logic       clk_serial,
   input wire logic [4:0] periph_access_en,
   input wire logic       clk_cpu_en,
   input wire logic       clk_io_en,
   input wire logic       main_osc_en,
   input wire logic       comparator_en,
   input wire logic       vref_en,
   input wire logic       brownout_en,
   input wire logic [7:0] input_buffer_en
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // gated clocks in the same bit order as periph_access_en
   wire logic [4:0] gclk = {clk_serial, clk_usb, clk_spi, clk_timer16, clk_timer8};

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   chk_gate_clock_phase: assert property (@(negedge aclk)
      ((gclk ^ periph_access_en) & ~(periph_access_en ^ $past(periph_access_en))) == 5'h00)
      else $error("gated clock high phase disagrees with access enable");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response missing one cycle after write");
   chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address accepted while response pending");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data missing one cycle after read address");
   chk_sleep_halts_cpu: assert property (sleep_active [*8] |-> !clk_cpu_en)
      else $error("cpu clock running during sleep");
   chk_io_stop_cpu: assert property (!clk_io_en |-> !clk_cpu_en && !comparator_en)
      else $error("io clock stopped outside deep sleep or comparator left on");
   chk_buffer_deep: assert property (!clk_io_en |-> input_buffer_en == (wake_pin_mask & ~digital_input_disable_reg))
      else $error("input buffers wrong while io clock stopped");
   chk_buffer_active: assert property (clk_io_en |-> input_buffer_en == ~digital_input_disable_reg)
      else $error("input buffers wrong while io clock runs");
   chk_vref_need: assert property (brownout_enabled_fuse || comparator_en |-> vref_en)
      else $error("reference off while needed");
   chk_brownout_fuse: assert property (brownout_en == brownout_enabled_fuse)
      else $error("brown-out detector does not follow fuse");
   chk_debug_osc: assert property (debug_enable_fuse |-> main_osc_en)
      else $error("main oscillator stopped with debug fuse set");

   cover property (periph_access_en == 5'h00);
   cover property (!clk_io_en && !main_osc_en);
   cover property (!clk_cpu_en && clk_io_en);
endmodule

bind peripheral_clock_gating peripheral_clock_gating_checker i_peripheral_clock_gating_checker (.*);

// file: testbench.sv
// self-checking bench for the peripheral clock gating block
// assumes the design, its package and the checker are compiled first
`timescale 1ns/1ps
`include "clock_gating_params.svh"

module testbench;
   import clock_gating_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, sleep_active = 0;
   logic brownout_enabled_fuse = 0, debug_enable_fuse = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [7:0]  wake_pin_mask = 8'h0f, digital_input_disable_reg = 8'h81, input_buffer_en;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic clk_timer8, clk_timer16, clk_spi, clk_usb, clk_serial, clk_cpu_en, clk_io_en;
   logic main_osc_en, comparator_en, vref_en, brownout_en, watchdog_run;
   logic [4:0]  periph_access_en;
   int n_fail = 0, n_checks = 0;
   int pos[5] = '{5, 3, 2, 7, 0};
   logic [2:0] modes[5] = '{3'b000, 3'b010, 3'b011, 3'b110, 3'b111};
   logic deep;

   peripheral_clock_gating i_peripheral_clock_gating (.*);

   always #4 aclk = ~aclk;

   // ----------------------------------------
   // bus tasks and comparison
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
      logic ha, hw;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid & ~ha) | (s_axi_wvalid & ~hw));
      do @(negedge aclk); while (!s_axi_bvalid);
      check("bresp", s_axi_bresp, er);
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_rvalid);
      check("rresp", s_axi_rresp, er);
      if (er === `RESP_OKAY) check("rdata", s_axi_rdata, exp);
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      #2;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`OFF_GATE_A, 0, `RESP_OKAY);
      rd(`OFF_GATE_B, 0, `RESP_OKAY);
      rd(32'h14, 0, `RESP_SLVERR);
      check("access", periph_access_en, 5'h1f);
      $display("test reset done");
      wr(`OFF_GATE_A, 32'hff, 4'h0, `RESP_OKAY);
      rd(`OFF_GATE_A, 0, `RESP_OKAY);
      wr(`OFF_GATE_A, 32'hff, 4'hf, `RESP_OKAY);
      rd(`OFF_GATE_A, 32'h2c, `RESP_OKAY);
      wr(`OFF_GATE_B, 32'hff, 4'hf, `RESP_OKAY);
      rd(`OFF_GATE_B, 32'h81, `RESP_OKAY);
      settle(1);
      check("gclk all", {clk_serial, clk_usb, clk_spi, clk_timer16, clk_timer8}, 0);
      wr(`OFF_GATE_A, 0, 4'hf, `RESP_OKAY);
      wr(`OFF_GATE_B, 0, 4'hf, `RESP_OKAY);
      for (int i = 0; i < 5; i++) begin
         wr(i < 3 ? `OFF_GATE_A : `OFF_GATE_B, 32'h1 << pos[i], 4'hf, `RESP_OKAY);
         settle(1);
         check("gclk one", {clk_serial, clk_usb, clk_spi, clk_timer16, clk_timer8}, 5'(~(5'h1 << i)));
         check("access one", periph_access_en, 5'(~(5'h1 << i)));
         wr(i < 3 ? `OFF_GATE_A : `OFF_GATE_B, 0, 4'hf, `RESP_OKAY);
         settle(1);
         check("gclk back", {clk_serial, clk_usb, clk_spi, clk_timer16, clk_timer8}, 5'h1f);
      end
      $display("test gating done");
      wr(`OFF_GATE_A, 32'h04, 4'hf, `RESP_OKAY);
      for (int i = 0; i < 5; i++) begin
         wr(`OFF_SLEEP_CTRL, {28'h0, modes[i], 1'b0}, 4'hf, `RESP_OKAY);
         sleep_active <= 1'b1;
         settle(8);
         deep = modes[i] != 3'b000;
         check("cpu", clk_cpu_en, 0);
         check("io", clk_io_en, !deep);
         check("osc", main_osc_en, modes[i][2] | !deep);
         check("cmp", comparator_en, !deep);
         check("vref", vref_en, !deep);
         check("buf", input_buffer_en, (deep ? 8'h0f : 8'hff) & 8'h7e);
         if (!deep) check("idle gate", {clk_spi, clk_timer8}, 2'b01);
      end
      wr(`OFF_SLEEP_CTRL, 32'h2, 4'hf, `RESP_OKAY);
      settle(2);
      check("io rsv", clk_io_en, 1);
      $display("test sleep done");
      wr(`OFF_SLEEP_CTRL, 32'h4, 4'hf, `RESP_OKAY);
      debug_enable_fuse <= 1'b1;
      wr(`OFF_ANALOG_CTRL, 32'h06, 4'hf, `RESP_OKAY);
      rd(`OFF_ANALOG_CTRL, 32'h06, `RESP_OKAY);
      settle(2);
      check("osc dbg", main_osc_en, 1);
      check("vref ref", vref_en, 1);
      check("wdt", watchdog_run, 1);
      rd(`OFF_STATUS, 32'ha5, `RESP_OKAY);
      brownout_enabled_fuse <= 1'b1;
      wr(`OFF_ANALOG_CTRL, 32'h01, 4'hf, `RESP_OKAY);
      settle(2);
      check("bod", {brownout_en, vref_en, comparator_en, watchdog_run}, 4'b1100);
      @(posedge aclk);
      brownout_enabled_fuse <= 1'b0;
      settle(2);
      check("vref off", vref_en, 0);
      @(posedge aclk);
      sleep_active <= 1'b0;
      $display("test fuses done");
      complete_run();
   end

   initial begin
      #200000;
      n_fail++;
      $display("[FAIL] watchdog expected finish seen timeout");
      complete_run();
   end
endmodule
